// file: rtl/rbl_fifo.sv
/*
 * rbl_fifo: parameterised byte buffer between link and ram writer.
 * assumes one clock; drain side may stall freely.
 */
`timescale 1ns/1ps
module rbl_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    // clock and reset
    input  wire logic             ref_clk,
    input  wire logic             rst_b,
    // fill side
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    // drain side
    output logic                  outValid,
    input  wire logic             outReady,
    output logic      [WIDTH-1:0] outData
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wrPtr_reg;
    logic [AW-1:0]    rdPtr_reg;
    logic [AW:0]      count_reg;
    logic [AW:0]      count_next;
    logic             ready_reg;
    logic             push;
    logic             pop;

    // ready is registered so the pin leaves from a flop
    assign inReady  = ready_reg;
    assign count_next = count_reg + (AW+1)'(push) - (AW+1)'(pop);
    assign outValid = (count_reg != '0);
    assign outData  = mem[rdPtr_reg];
    assign push     = inValid && inReady;
    assign pop      = outValid && outReady;

    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem[wrPtr_reg] <= inData;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            wrPtr_reg <= '0;
            rdPtr_reg <= '0;
            count_reg <= '0;
            ready_reg <= 1'b0;
        end else begin
            if (push) begin
                wrPtr_reg <= (wrPtr_reg == AW'(DEPTH-1)) ?
                             '0 : wrPtr_reg + 1'b1;
            end
            if (pop) begin
                rdPtr_reg <= (rdPtr_reg == AW'(DEPTH-1)) ?
                             '0 : rdPtr_reg + 1'b1;
            end
            count_reg <= count_next;
            ready_reg <= (count_next != (AW+1)'(DEPTH));
        end
    end
endmodule

// file: rtl/rbl_loader.sv
/*
 * rbl_loader: ram bootstrap loader; serial and parallel fill of ram,
 * jump-to-ram start, interrupt pseudo-vector redirection.
 * assumes bytes arrive as a valid pulse from a receiver, ram write port
 * outside, mode pins stable around reset release, and a crystal tick
 * derived here by division of ref_clk.
 */
// Functional notes
// - a first byte below B0 is a count; that many bytes go to 0050 upward.
// - a count not smaller than the first region (B0) is ignored; filling continues.
// - in the extended fill, run from 0051 when ram is full or 5 ms quiet.
// - in loader mode each vector is redirected to a three-byte ram slot.
// - slots: sci 0063, tov 0060, toc 005D, tic 005A, irq 0057, swi 0054.
// - parallel timing counts machine cycles of twice the crystal period.
// - without handshake one load cycle takes 49 machine cycles.
// - handshake out changes 5 machine cycles after its trigger.
`timescale 1ns/1ps
module rbl_loader #(
    parameter int QUIET_CYCLES = rbl_pkg::QUIET_CYC
) (
    // clock and reset
    input  wire logic                     ref_clk,
    input  wire logic                     rst_b,
    // mode-select pins
    input  wire logic                     modeSelectA,
    input  wire logic                     modeSelectB,
    input  wire logic                     modeSelectC,
    input  wire logic                     modeSelectD,
    // serial byte stream
    input  wire logic                     rxValid,
    input  wire rbl_pkg::rbl_byte_s       rxByte,
    output logic                          rxReady,
    // parallel load port
    input  wire rbl_pkg::rbl_byte_s       parData,
    input  wire logic                     handshakeInPin,
    output logic                          handshakeOutPin,
    output logic [rbl_pkg::ADDR_W-1:0]    parAddr,
    // ram write port
    output rbl_pkg::rbl_ram_wr_s          ramWr,
    // vector redirection
    input  wire rbl_pkg::rbl_vec_t        vecSel,
    output logic [rbl_pkg::ADDR_W-1:0]    vecAddr,
    // execution control
    output logic                          runStart,
    output logic [rbl_pkg::ADDR_W-1:0]    runAddr,
    output logic                          loaderMode
);
    import rbl_pkg::*;

    typedef enum logic [2:0] {
        ST_STRAP,
        ST_FIRST,
        ST_DATA,
        ST_PAR,
        ST_RUN,
        ST_IDLE
    } rbl_state_e;

    typedef struct packed {
        rbl_state_e        state;
        rbl_mode_e         mode;
        logic              counted;
        logic [7:0]        remain;
        logic [ADDR_W-1:0] addr;
        logic [31:0]       quiet;
        logic [3:0]        xdiv;
        logic [5:0]        mc;
        logic              hsOut;
        logic              hsSeen;
        rbl_ram_wr_s       wr;
        logic              run;
        logic [ADDR_W-1:0] runA;
        logic [ADDR_W-1:0] vec;
        logic              ldr;
    } rbl_st_s;

    rbl_st_s st_reg;
    rbl_st_s st_next;

    logic      fifoValid;
    logic      fifoPop;
    rbl_byte_s fifoByte;
    logic      mcTick;
    logic      hsDisabled;

    ////////////////////////////////////////////////////////////////////
    // byte buffer; stalls the receiver when the writer lags
    rbl_fifo #(
        .WIDTH (DATA_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .ref_clk  (ref_clk),
        .rst_b    (rst_b),
        .inValid  (rxValid),
        .inReady  (rxReady),
        .inData   (rxByte),
        .outValid (fifoValid),
        .outReady (fifoPop),
        .outData  (fifoByte)
    );

    ////////////////////////////////////////////////////////////////////
    // machine-cycle tick: one per two crystal periods
    assign mcTick     = (st_reg.xdiv == 4'(XTAL_HALF_DIV - 1));
    // outputs looped back mean no handshake partner
    assign hsDisabled = (handshakeInPin == st_reg.hsOut);
    assign fifoPop    = fifoValid &&
                        (st_reg.state == ST_FIRST || st_reg.state == ST_DATA);

    always_comb begin
        st_next       = st_reg;
        st_next.wr.we = 1'b0;
        st_next.run   = 1'b0;
        st_next.xdiv  = mcTick ? '0 : st_reg.xdiv + 4'h1;
        unique case (vecSel)
            3'h0:    st_next.vec = PV_SCI;
            3'h1:    st_next.vec = PV_TOV;
            3'h2:    st_next.vec = PV_TOC;
            3'h3:    st_next.vec = PV_TIC;
            3'h4:    st_next.vec = PV_IRQ;
            3'h5:    st_next.vec = PV_SWI;
            default: st_next.vec = PV_SWI;
        endcase
        unique case (st_reg.state)
            ST_STRAP: begin
                // sampled one clock after release, never under reset
                if (modeSelectA && !modeSelectB && !modeSelectC &&
                    modeSelectD) begin
                    st_next.mode  = RBL_MODE_JUMP;
                    st_next.state = ST_RUN;
                end else if (!modeSelectB && modeSelectC &&
                             modeSelectD) begin
                    st_next.mode  = RBL_MODE_SERIAL;
                    st_next.state = ST_FIRST;
                    st_next.ldr   = 1'b1;
                end else if (modeSelectA && !modeSelectB) begin
                    st_next.mode  = RBL_MODE_PARALLEL;
                    st_next.state = ST_PAR;
                    st_next.ldr   = 1'b1;
                end else begin
                    st_next.state = ST_IDLE;
                end
                st_next.addr = RAM1_START;
                // tick phase restarts so the first load cycle is full
                st_next.xdiv = '0;
            end
            ST_FIRST: begin
                if (fifoValid) begin
                    // oversize counts fall back to an uncounted fill
                    st_next.counted =
                        (fifoByte.data < COUNT_LIMIT);
                    st_next.remain  = fifoByte.data;
                    st_next.quiet   = '0;
                    st_next.state   = ST_DATA;
                    if (fifoByte.data == 8'h00) begin
                        st_next.state = ST_RUN;
                    end
                end
            end
            ST_DATA: begin
                st_next.quiet = st_reg.quiet + 32'h1;
                if (fifoValid) begin
                    st_next.quiet   = '0;
                    st_next.wr.we   = 1'b1;
                    st_next.wr.addr = st_reg.addr;
                    st_next.wr.data = fifoByte.data;
                    st_next.addr    = st_reg.addr + 16'h1;
                    st_next.remain  = st_reg.remain - 8'h1;
                    if (st_reg.counted &&
                        (st_reg.remain == 8'h1 ||
                         st_reg.addr == RAM1_END)) begin
                        st_next.state = ST_RUN;
                    end else if (st_reg.addr == RAM2_END) begin
                        st_next.state = ST_RUN;
                    end
                end else if (!st_reg.counted &&
                             st_reg.quiet >= 32'(QUIET_CYCLES - 1)) begin
                    st_next.state = ST_RUN;
                end
            end
            ST_PAR: begin
                if (mcTick) begin
                    st_next.mc = st_reg.mc + 6'h1;
                    // handshake edge seen within the window counts now
                    if (!hsDisabled && st_reg.mc < 6'(RECOG_MC)) begin
                        st_next.hsSeen = 1'b1;
                    end
                    if (st_reg.mc == 6'(HS_OUT_MC - 1)) begin
                        st_next.hsOut = ~st_reg.hsOut;
                    end
                    if (st_reg.mc == 6'(SAMPLE_MC)) begin
                        st_next.wr.we   = hsDisabled || st_reg.hsSeen;
                        st_next.wr.addr = st_reg.addr;
                        st_next.wr.data = parData.data;
                    end
                    if (st_reg.mc == 6'(LOAD_CYCLE_MC - 1)) begin
                        st_next.mc     = '0;
                        st_next.hsSeen = 1'b0;
                        st_next.addr   = st_reg.addr + 16'h1;
                        if (st_reg.addr == RAM2_END) begin
                            st_next.state = ST_RUN;
                        end
                    end
                end
            end
            ST_RUN: begin
                st_next.run   = 1'b1;
                st_next.runA  = EXEC_START;
                st_next.state = ST_IDLE;
            end
            default: begin
                st_next.state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            st_reg       <= '0;
            st_reg.state <= ST_STRAP;
            st_reg.vec   <= PV_SCI;
        end else begin
            st_reg <= st_next;
        end
    end

    assign handshakeOutPin = st_reg.hsOut;
    assign parAddr         = st_reg.addr;
    assign ramWr           = st_reg.wr;
    assign vecAddr         = st_reg.vec;
    assign runStart        = st_reg.run;
    assign runAddr         = st_reg.runA;
    assign loaderMode      = st_reg.ldr;
endmodule

// file: rtl/rbl_pkg.sv
/*
 * rbl_pkg: shared constants and carriers of the ram bootstrap loader.
 * assumes a 125 MHz ref_clk and a crystal-derived machine-cycle tick.
 */
package rbl_pkg;
    localparam int  CLK_MHZ         = 125;
    localparam int  ADDR_W          = 16;
    localparam int  DATA_W          = 8;
    localparam int  FIFO_DEPTH      = 16;
    localparam logic [7:0]  COUNT_LIMIT   = 8'hB0;
    localparam logic [15:0] RAM1_START    = 16'h0050;
    localparam logic [15:0] RAM1_END      = 16'h00FF;
    localparam logic [15:0] RAM2_START    = 16'h0100;
    localparam logic [15:0] RAM2_END      = 16'h024F;
    localparam logic [15:0] EXEC_START    = 16'h0051;
    localparam logic [15:0] PV_SCI        = 16'h0063;
    localparam logic [15:0] PV_TOV        = 16'h0060;
    localparam logic [15:0] PV_TOC        = 16'h005D;
    localparam logic [15:0] PV_TIC        = 16'h005A;
    localparam logic [15:0] PV_IRQ        = 16'h0057;
    localparam logic [15:0] PV_SWI        = 16'h0054;
    localparam int  QUIET_MS        = 5;
    localparam int  QUIET_CYC       = QUIET_MS * CLK_MHZ * 1000;
    localparam int  LOAD_CYCLE_MC   = 49;
    localparam int  HS_OUT_MC       = 5;
    localparam int  SAMPLE_MC       = 16;
    localparam int  RECOG_MC        = 30;
    localparam int  XTAL_HALF_DIV   = 4;

    // boot modes picked by the mode-select pins at reset release
    typedef enum logic [1:0] {
        RBL_MODE_NONE,
        RBL_MODE_JUMP,
        RBL_MODE_SERIAL,
        RBL_MODE_PARALLEL
    } rbl_mode_e;

    typedef struct packed {
        logic [DATA_W-1:0] data;
    } rbl_byte_s;

    typedef struct packed {
        logic              we;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } rbl_ram_wr_s;

    // vector number 0..5: sci, tov, toc, tic, irq, swi
    typedef logic [2:0] rbl_vec_t;
endpackage

// file: tb/rbl_host_model.sv
/* rbl_host_model: host feeding serial bytes and a parallel source.
   assumes the bench calls sendByte; parallel side is loopback. */
`timescale 1ns/1ps
module rbl_host_model
    import rbl_pkg::*;
(
    input wire logic              ref_clk,
    // serial stream
    output logic                  rxValid,
    output rbl_pkg::rbl_byte_s    rxByte,
    input wire logic              rxReady,
    // parallel source
    input wire logic [ADDR_W-1:0] parAddr,
    input wire logic              handshakeOutPin,
    output rbl_pkg::rbl_byte_s    parData,
    output logic                  handshakeInPin
);
    logic stuck = 1'b0;
    initial {rxValid, rxByte} = 9'h000;
    // data follows the address at once and holds until the next one
    assign parData.data = parAddr[7:0] ^ 8'hA5;
    assign handshakeInPin = handshakeOutPin;
    task automatic sendByte(input logic [7:0] b);
        int n;
        @(negedge ref_clk);
        rxValid = 1'b1;
        rxByte.data = b;
        n = 0;
        while (rxReady !== 1'b1 && n < 100) begin
            @(negedge ref_clk);
            n++;
        end
        if (n >= 100) stuck = 1'b1;
        @(posedge ref_clk);
        @(negedge ref_clk);
        rxValid = 1'b0;
        // released line shows the inverse, not a stale byte
        rxByte.data = ~b;
    endtask
endmodule

// file: tb/rbl_loader_bench.sv
/* rbl_loader_bench: self-checking bench of the loader.
   assumes rbl_host_model as the far side and a short quiet time. */
`timescale 1ns/1ps
module rbl_loader_bench;
    import rbl_pkg::*;
    typedef struct packed {rbl_vec_t sel; logic [15:0] exp;} rbl_vrow_s;
    logic ref_clk, rst_b, modeSelectA, modeSelectB, modeSelectC, modeSelectD;
    logic rxValid, rxReady, handshakeInPin, handshakeOutPin, runStart;
    logic loaderMode, runSeen;
    rbl_byte_s rxByte, parData;
    logic [ADDR_W-1:0] parAddr, vecAddr, runAddr;
    rbl_ram_wr_s ramWr;
    rbl_vec_t vecSel;
    int n_errors = 0;
    int tests_run = 0;
    logic [15:0] wrAddr[$];
    logic [7:0] wrData[$];
    rbl_vrow_s vecRows[8] = '{'{3'h0, PV_SCI}, '{3'h1, PV_TOV},
        '{3'h2, PV_TOC}, '{3'h3, PV_TIC}, '{3'h4, PV_IRQ},
        '{3'h5, PV_SWI}, '{3'h6, PV_SWI}, '{3'h7, PV_SWI}};
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    rbl_loader #(.QUIET_CYCLES(50)) u_rbl_loader (.ref_clk(ref_clk),
        .rst_b(rst_b), .modeSelectA(modeSelectA), .modeSelectB(modeSelectB),
        .modeSelectC(modeSelectC), .modeSelectD(modeSelectD),
        .rxValid(rxValid), .rxByte(rxByte), .rxReady(rxReady),
        .parData(parData), .handshakeInPin(handshakeInPin),
        .handshakeOutPin(handshakeOutPin), .parAddr(parAddr), .ramWr(ramWr),
        .vecSel(vecSel), .vecAddr(vecAddr), .runStart(runStart),
        .runAddr(runAddr), .loaderMode(loaderMode));
    rbl_host_model u_rbl_host_model (.ref_clk(ref_clk), .rxValid(rxValid),
        .rxByte(rxByte), .rxReady(rxReady), .parAddr(parAddr),
        .handshakeOutPin(handshakeOutPin), .parData(parData),
        .handshakeInPin(handshakeInPin));
    always @(negedge ref_clk) begin
        if (ramWr.we === 1'b1) begin
            wrAddr.push_back(ramWr.addr);
            wrData.push_back(ramWr.data);
        end
        if (runStart === 1'b1) runSeen = 1'b1;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic chkVal(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic test_done;
        $display("mismatches %0d of %0d checks", n_errors, tests_run);
        if (n_errors == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic doReset(input logic [3:0] m);
        @(negedge ref_clk);
        rst_b = 1'b0;
        {modeSelectA, modeSelectB, modeSelectC, modeSelectD} = m;
        repeat (10) @(negedge ref_clk);
        chkVal(vecAddr, PV_SCI);
        chkVal({15'h0000, runStart}, 16'h0000);
        wrAddr.delete();
        wrData.delete();
        runSeen = 1'b0;
        rst_b = 1'b1;
    endtask
    task automatic waitRun(input int lim);
        int n;
        n = 0;
        while (runSeen !== 1'b1 && n < lim) begin
            @(negedge ref_clk);
            n++;
        end
        if (runSeen !== 1'b1) begin
            n_errors++;
            $display("BAD %0t no start", $time);
            test_done();
        end
    endtask
    task automatic sendRun(input logic [7:0] first, input int n);
        u_rbl_host_model.sendByte(first);
        for (int i = 0; i < n; i++) u_rbl_host_model.sendByte(8'h3C + 8'(i));
    endtask
    task automatic chkLoad(input int n);
        chkVal(16'(wrAddr.size()), 16'(n));
        foreach (wrAddr[i]) begin
            chkVal(wrAddr[i], RAM1_START + 16'(i));
            chkVal({8'h00, wrData[i]}, {8'h00, 8'h3C + 8'(i)});
        end
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        int n;
        {rst_b, vecSel, modeSelectA, modeSelectB} = 6'h00;
        {modeSelectC, modeSelectD, runSeen} = 3'h0;
        doReset(4'b0011);
        foreach (vecRows[i]) begin
            @(negedge ref_clk);
            vecSel = vecRows[i].sel;
            @(negedge ref_clk);
            chkVal(vecAddr, vecRows[i].exp);
        end
        chkVal({15'h0000, loaderMode}, 16'h0001);
        sendRun(8'h03, 3);
        waitRun(20);
        chkLoad(3);
        chkVal(runAddr, EXEC_START);
        doReset(4'b0011);
        sendRun(8'hAF, 175);
        waitRun(20);
        chkLoad(175);
        doReset(4'b0011);
        sendRun(COUNT_LIMIT, 4);
        repeat (5) @(negedge ref_clk);
        chkVal({15'h0000, runSeen}, 16'h0000);
        waitRun(80);
        chkLoad(4);
        doReset(4'b1011);
        sendRun(8'hFF, 512);
        waitRun(10);
        chkLoad(512);
        doReset(4'b0011);
        sendRun(8'h00, 0);
        waitRun(20);
        chkVal(16'(wrAddr.size()), 16'h0000);
        doReset(4'b1001);
        waitRun(4);
        chkVal(runAddr, EXEC_START);
        chkVal(16'(wrAddr.size()), 16'h0000);
        chkVal({15'h0000, loaderMode}, 16'h0000);
        doReset(4'b1000);
        n = 0;
        while (wrAddr.size() < 3 && n < 1000) begin
            @(negedge ref_clk);
            n++;
        end
        chkVal(16'(wrAddr.size()), 16'h0003);
        foreach (wrData[i]) begin
            chkVal(wrAddr[i], RAM1_START + 16'(i));
            chkVal(16'(wrData[i] ^ 8'hA5), 16'(wrAddr[i][7:0]));
        end
        chkVal({15'h0000, u_rbl_host_model.stuck}, 16'h0000);
        test_done();
    end
endmodule
bind rbl_loader rbl_loader_chk u_rbl_loader_chk (.ref_clk(ref_clk),
    .rst_b(rst_b), .modeSelectA(modeSelectA), .modeSelectB(modeSelectB),
    .modeSelectC(modeSelectC), .modeSelectD(modeSelectD), .parAddr(parAddr),
    .handshakeOutPin(handshakeOutPin), .ramWr(ramWr), .vecSel(vecSel),
    .vecAddr(vecAddr), .runStart(runStart), .runAddr(runAddr));

// file: tb/rbl_loader_chk.sv
/* rbl_loader_chk: timing, address and vector checks on the loader ports.
   assumes a bind onto rbl_loader, one clock, rst_b async low. */
`timescale 1ns/1ps
module rbl_loader_chk
    import rbl_pkg::*;
(
    // clock and reset
    input wire logic               ref_clk,
    input wire logic               rst_b,
    // mode pins
    input wire logic               modeSelectA,
    input wire logic               modeSelectB,
    input wire logic               modeSelectC,
    input wire logic               modeSelectD,
    // outputs watched, plus the vecSel input
    input wire logic [ADDR_W-1:0]  parAddr,
    input wire logic               handshakeOutPin,
    input wire rbl_pkg::rbl_ram_wr_s ramWr,
    input wire rbl_pkg::rbl_vec_t  vecSel,
    input wire logic [ADDR_W-1:0]  vecAddr,
    input wire logic               runStart,
    input wire logic [ADDR_W-1:0]  runAddr
);
    logic first, parSel, serSel, seen;
    logic [7:0] gap;
    logic [15:0] nxt;
    function automatic logic [15:0] vecExp(input logic [2:0] s);
        case (s)
            3'h0: return PV_SCI;
            3'h1: return PV_TOV;
            3'h2: return PV_TOC;
            3'h3: return PV_TIC;
            3'h4: return PV_IRQ;
            default: return PV_SWI;
        endcase
    endfunction
    // mode latched like the design: first edge after release
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            {first, parSel, serSel, seen, gap} <= {1'b1, 11'h000};
            nxt <= RAM1_START;
        end else begin
            first <= 1'b0;
            if (first) begin
                parSel <= modeSelectA & !modeSelectB & !modeSelectD;
                serSel <= modeSelectC & modeSelectD & !modeSelectB;
            end
            gap <= $changed(parAddr) ? 8'h00 : gap + 8'h01;
            if ($changed(parAddr)) seen <= 1'b1;
            if (ramWr.we) nxt <= ramWr.addr + 16'h0001;
        end
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    a_vec_target: assert property (
        1'b1 |=> vecAddr == vecExp($past(vecSel)))
        else $error("vector target wrong");
    a_run_addr: assert property (runStart |=> runAddr == EXEC_START)
        else $error("start address wrong");
    a_run_once: assert property (runStart |=> !runStart)
        else $error("start not a pulse");
    a_jump_entry: assert property (
        $rose(rst_b) && modeSelectA && !modeSelectB && !modeSelectC
        && modeSelectD |-> ##[1:2] runStart)
        else $error("jump mode did not start");
    a_wr_window: assert property (
        ramWr.we && serSel |-> ramWr.addr >= RAM1_START
        && ramWr.addr <= RAM2_END)
        else $error("write outside ram");
    a_wr_order: assert property (
        ramWr.we && serSel |-> ramWr.addr == nxt)
        else $error("write address skipped");
    a_load_period: assert property (
        $changed(parAddr) && parSel && seen |-> gap == 8'd195)
        else $error("load cycle not 49 ticks");
    a_hs_delay: assert property (
        $changed(parAddr) && parSel && seen
        |-> ##[16:24] $changed(handshakeOutPin))
        else $error("handshake out late");
endmodule
